// ==== timer_defs.vh ====
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// register indices; byte address on the bus is four times the index
`define TIMER0_MATCH_HIGH_IDX 12'h0F04
`define TIMER0_MATCH_LOW_IDX  12'h0F05
`define TIMER1_MATCH_HIGH_IDX 12'h0F0C
`define TIMER1_MATCH_LOW_IDX  12'h0F0D
`define TIMER2_MATCH_HIGH_IDX 12'h0F14
`define TIMER2_MATCH_LOW_IDX  12'h0F15
`define TIMER3_MATCH_HIGH_IDX 12'h0F1C
`define TIMER3_MATCH_LOW_IDX  12'h0F1D
// timer banks: index[11:5] selects the bank area, index[4:3] the timer, index[2:0] the field
`define TIMER_BANK_SEL        7'h78
`define FLD_COUNT_HIGH        3'h0
`define FLD_COUNT_LOW         3'h1
`define FLD_RELOAD_HIGH       3'h2
`define FLD_RELOAD_LOW        3'h3
`define FLD_MATCH_HIGH        3'h4
`define FLD_MATCH_LOW         3'h5
`define FLD_CONTROL           3'h6
`define IRQ_STATUS_IDX        12'h0F20
`define IRQ_MASK_IDX          12'h0F21
// control register fields
`define CTL_ENABLE            7
`define CTL_POLARITY          6
`define CTL_MODE_MSB          1
`define CTL_MODE_LSB          0
`define MODE_COUNTER          2'h0
`define MODE_PWM              2'h1
`define MODE_CAPTURE          2'h2
`define MODE_CAPTURE_COMPARE  2'h3
// reset and restart values
`define BYTE_RESET            8'h00
`define COUNT_RESET           16'h0000
`define COUNT_RESTART         16'h0001
`define NIBBLE_RESET          4'h0
`endif

// ==== timer_channel.v ====
`include "timer_defs.vh"

module timer_channel (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        enable,
    input  wire        polarity,
    input  wire [1:0]  mode,
    input  wire [15:0] reloadValue,
    input  wire [15:0] matchValue,
    input  wire        loadHigh,
    input  wire        loadLow,
    input  wire [7:0]  loadByte,
    input  wire        timerIn,
    output reg  [15:0] count,
    output reg         timerOut,
    output reg         reloadPulse,
    output reg         capturePulse,
    output reg  [15:0] captureValue
);

    reg         prevIn;
    reg         wasEnabled;
    wire        selEdge;
    wire        counterMode;
    wire        pwmMode;
    wire        captureMode;
    wire        step;
    wire        atReload;

    // polarity 0 counts rising edges, polarity 1 falling edges
    assign selEdge     = polarity ? (prevIn & ~timerIn) : (~prevIn & timerIn);
    assign counterMode = (mode == `MODE_COUNTER);
    assign pwmMode     = (mode == `MODE_PWM);
    assign captureMode = (mode == `MODE_CAPTURE) | (mode == `MODE_CAPTURE_COMPARE);
    // counter mode steps on input edges, all other modes on every system clock
    assign step        = counterMode ? selEdge : 1'b1;
    assign atReload    = (count == reloadValue);

    // count, reload and capture; a software load beats a step in the same cycle
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count        <= `COUNT_RESET;
            prevIn       <= 1'b0;
            wasEnabled   <= 1'b0;
            reloadPulse  <= 1'b0;
            capturePulse <= 1'b0;
            captureValue <= `COUNT_RESET;
        end else begin
            prevIn       <= timerIn;
            wasEnabled   <= enable;
            reloadPulse  <= 1'b0;
            capturePulse <= 1'b0;
            if (loadHigh | loadLow) begin
                // start value only holds until the first reload
                if (loadHigh) begin
                    count[15:8] <= loadByte;
                end
                if (loadLow) begin
                    count[7:0] <= loadByte;
                end
            end else if (enable & step) begin
                if (atReload) begin
                    count       <= `COUNT_RESTART;
                    reloadPulse <= 1'b1;
                end else begin
                    count <= count + 16'h0001;
                end
            end
            if (enable & captureMode & selEdge) begin
                capturePulse <= 1'b1;
                captureValue <= count;
            end
        end
    end

    // output level; idle and first enabled cycle show the polarity level
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            timerOut <= 1'b0;
        end else if (!enable || !wasEnabled) begin
            timerOut <= polarity;
        end else if (pwmMode & atReload) begin
            timerOut <= polarity;
        end else if (pwmMode & (count == matchValue)) begin
            timerOut <= ~timerOut;
        end else if (counterMode & step & atReload) begin
            timerOut <= ~timerOut;
        end
    end

endmodule // timer_channel

// ==== timer_block.v ====
`include "timer_defs.vh"

module timer_block (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [3:0]  timerIn,
    output wire [3:0]  timerOut,
    output reg         irq
);

    // register index and bus phase decode
    wire [11:0] regIndex;
    wire [1:0]  timerSel;
    wire [2:0]  fieldSel;
    wire        bankHit;
    wire        statusHit;
    wire        maskHit;
    wire        addrHit;
    wire        accessPhase;
    wire        commit;
    wire        wrCommit;
    wire [7:0]  wrByte;

    assign regIndex    = paddr[13:2];
    assign timerSel    = regIndex[4:3];
    assign fieldSel    = regIndex[2:0];
    assign bankHit     = (regIndex[11:5] == `TIMER_BANK_SEL) && (fieldSel <= `FLD_CONTROL);
    assign statusHit   = (regIndex == `IRQ_STATUS_IDX);
    assign maskHit     = (regIndex == `IRQ_MASK_IDX);
    // word alignment and the top address bits are part of the decode
    assign addrHit     = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00)
                         && (bankHit | statusHit | maskHit);
    // the slave answers one cycle into the access phase
    assign accessPhase = psel & penable & ~pready;
    // writes land only at the edge where the master sees pready high
    assign commit      = psel & penable & pready;
    assign wrCommit    = commit & pwrite & addrHit;
    assign wrByte      = pwdata[7:0];

    // flattened per-timer state for the read path and interrupt logic
    wire [31:0] ctlBus;
    wire [31:0] reloadHighBus;
    wire [31:0] reloadLowBus;
    wire [31:0] matchHighBus;
    wire [31:0] matchLowBus;
    wire [63:0] countBus;
    wire [3:0]  timerEvent;

    reg  [3:0]  irqStatus;
    reg  [3:0]  irqMask;
    reg  [3:0]  next_irqStatus;
    reg  [7:0]  next_rdata;

    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1) begin : chan
            reg  [7:0]  ctl;
            reg  [7:0]  reloadHigh;
            reg  [7:0]  reloadLow;
            reg  [7:0]  matchHigh;
            reg  [7:0]  matchLow;
            wire        hitThis;
            wire        reloadPulse;
            wire        capturePulse;
            wire [15:0] captureValue;
            wire [15:0] count;

            assign hitThis = wrCommit & bankHit & (timerSel == n);

            // control, reload and match bytes of one timer
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    ctl        <= `BYTE_RESET;
                    reloadHigh <= `BYTE_RESET;
                    reloadLow  <= `BYTE_RESET;
                    matchHigh  <= `BYTE_RESET;
                    matchLow   <= `BYTE_RESET;
                end else begin
                    if (hitThis && fieldSel == `FLD_CONTROL) begin
                        ctl <= wrByte;
                    end
                    if (hitThis && fieldSel == `FLD_RELOAD_HIGH) begin
                        reloadHigh <= wrByte;
                    end
                    if (hitThis && fieldSel == `FLD_RELOAD_LOW) begin
                        reloadLow <= wrByte;
                    end
                    // a capture wins over a software write in the same cycle
                    if (capturePulse) begin
                        matchHigh <= captureValue[15:8];
                        matchLow  <= captureValue[7:0];
                    end else begin
                        if (hitThis && fieldSel == `FLD_MATCH_HIGH) begin
                            matchHigh <= wrByte;
                        end
                        if (hitThis && fieldSel == `FLD_MATCH_LOW) begin
                            matchLow <= wrByte;
                        end
                    end
                end
            end

            timer_channel u_channel (
                .clk_sys      (clk_sys),
                .resetn       (resetn),
                .enable       (ctl[`CTL_ENABLE]),
                .polarity     (ctl[`CTL_POLARITY]),
                .mode         (ctl[`CTL_MODE_MSB:`CTL_MODE_LSB]),
                .reloadValue  ({reloadHigh, reloadLow}),
                .matchValue   ({matchHigh, matchLow}),
                .loadHigh     (hitThis && fieldSel == `FLD_COUNT_HIGH),
                .loadLow      (hitThis && fieldSel == `FLD_COUNT_LOW),
                .loadByte     (wrByte),
                .timerIn      (timerIn[n]),
                .count        (count),
                .timerOut     (timerOut[n]),
                .reloadPulse  (reloadPulse),
                .capturePulse (capturePulse),
                .captureValue (captureValue)
            );

            assign ctlBus[8*n +: 8]        = ctl;
            assign reloadHighBus[8*n +: 8] = reloadHigh;
            assign reloadLowBus[8*n +: 8]  = reloadLow;
            assign matchHighBus[8*n +: 8]  = matchHigh;
            assign matchLowBus[8*n +: 8]   = matchLow;
            assign countBus[16*n +: 16]    = count;
            // reloads and captures both raise the timer's event
            assign timerEvent[n]           = reloadPulse | capturePulse;
        end
    endgenerate

    // read data selection; unmapped reads return zero
    always @* begin
        next_rdata = `BYTE_RESET;
        if (statusHit) begin
            next_rdata = {`NIBBLE_RESET, irqStatus};
        end else if (maskHit) begin
            next_rdata = {`NIBBLE_RESET, irqMask};
        end else if (bankHit) begin
            case (fieldSel)
                `FLD_COUNT_HIGH:  next_rdata = countBus[16*timerSel + 8 +: 8];
                `FLD_COUNT_LOW:   next_rdata = countBus[16*timerSel +: 8];
                `FLD_RELOAD_HIGH: next_rdata = reloadHighBus[8*timerSel +: 8];
                `FLD_RELOAD_LOW:  next_rdata = reloadLowBus[8*timerSel +: 8];
                `FLD_MATCH_HIGH:  next_rdata = matchHighBus[8*timerSel +: 8];
                `FLD_MATCH_LOW:   next_rdata = matchLowBus[8*timerSel +: 8];
                `FLD_CONTROL:     next_rdata = ctlBus[8*timerSel +: 8];
                default:          next_rdata = `BYTE_RESET;
            endcase
        end
    end

    // apb answer: pready pulses one cycle after the access phase starts
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= accessPhase;
            pslverr <= accessPhase & ~addrHit;
            if (accessPhase) begin
                // data sampled one cycle early; the count may move meanwhile
                // a refused access reads zero even where the index alone decodes
                prdata <= addrHit ? {24'h00_0000, next_rdata} : 32'h0000_0000;
            end
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always @* begin
        next_irqStatus = irqStatus;
        if (wrCommit && statusHit) begin
            next_irqStatus = irqStatus & ~pwdata[3:0];
        end
        next_irqStatus = next_irqStatus | timerEvent;
    end

    // status, mask and the registered interrupt line
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqStatus <= `NIBBLE_RESET;
            irqMask   <= `NIBBLE_RESET;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrCommit && maskHit) begin
                irqMask <= pwdata[3:0];
            end
            // registered so the pin is glitch free; one cycle behind status
            irq <= |(irqStatus & irqMask);
        end
    end

endmodule // timer_block

// ==== timer_block_properties.sv ====
module timer_block_properties (
    input wire        clk_sys,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  timerIn,
    input wire [3:0]  timerOut,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // a write that completes at this edge
    sequence wr_done(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    // the slave owes exactly one wait state
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr alone");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_misaligned_refused: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned accepted");
    // masking everything must drop irq two edges after the write lands
    a_mask_off_quiet: assert property (
        wr_done(16'h3c84) ##0 pwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq despite zero mask");
    // a disabled timer 0 shows its polarity bit
    a_idle_level: assert property (
        wr_done(16'h3c18) ##0 !pwdata[7] |-> ##2 timerOut[0] == $past(pwdata[6], 2))
        else $error("idle level wrong");
endmodule // timer_block_properties

// ==== timer_pin_model.sv ====
module timer_pin_model (
    input  wire        clk_sys,
    input  wire [3:0]  timerOut,
    output logic [3:0] timerIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // inputs idle low; the level is held, so no release state exists
    initial timerIn = 4'h0;
    // change one pin after an edge, then give sync and count time
    task automatic set_level(input int n, input logic v);
        @(posedge clk_sys);
        timerIn[n] <= v;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic pulses(input int n, input int k);
        repeat (k) begin
            set_level(n, 1'b1);
            set_level(n, 1'b0);
        end
    endtask
endmodule // timer_pin_model

// ==== tb.sv ====
`include "timer_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  timerIn;
    logic [3:0]  timerOut;
    logic        irq;
    logic [31:0] q;
    logic        err;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          highs;
    always #2.5 clk_sys = ~clk_sys;
    timer_block dut_u (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerIn(timerIn), .timerOut(timerOut), .irq(irq));
    timer_pin_model pins_u (.clk_sys(clk_sys), .timerOut(timerOut), .timerIn(timerIn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one transfer; entered just after an edge, one idle edge after release
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no wait-state count assumed; only the watchdog ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic logic [15:0] ta(input int n, input logic [2:0] f);
        return {2'b00, `TIMER_BANK_SEL, n[1:0], f, 2'b00};
    endfunction
    task automatic rdc(input int n, output logic [15:0] c);
        apb(1'b0, ta(n, `FLD_COUNT_HIGH), 32'h0);
        c[15:8] = q[7:0];
        apb(1'b0, ta(n, `FLD_COUNT_LOW), 32'h0);
        c[7:0] = q[7:0];
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // cut a hang short well past the expected run of about 3200 cycles
    initial begin
        #200us;
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        logic [15:0] c;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        // match bytes reset to zero and keep what is written
        for (int n = 0; n < 4; n++) begin
            for (int f = 4; f < 6; f++) begin
                apb(1'b0, ta(n, f[2:0]), 32'h0);
                chk(q, 32'h0000_0000, "match reset");
                apb(1'b1, ta(n, f[2:0]), 32'h0000_00a5 + f);
                apb(1'b0, ta(n, f[2:0]), 32'h0);
                chk(q, 32'h0000_00a5 + f, "match readback");
            end
        end
        apb(1'b0, 16'h0004, 32'h0);
        chk({q[30:0], err}, 32'h0000_0001, "unmapped read");
        apb(1'b0, 16'h3c11, 32'h0);
        chk({q[30:0], err}, 32'h0000_0001, "misaligned read");
        apb(1'b1, 16'h3c11, 32'h0000_00ff);
        chk(err, 1'b1, "misaligned write");
        $display("test registers done");
        // pwm on timer 0: reload 0105, match 0100, both polarities
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, ta(0, `FLD_CONTROL), {24'h0, 1'b0, p[0], 6'h00});
            // the pin follows the control byte one edge after the write lands
            @(posedge clk_sys);
            chk(timerOut[0], p[0], "idle level");
            apb(1'b1, ta(0, `FLD_RELOAD_HIGH), 32'h0000_0001);
            apb(1'b1, ta(0, `FLD_RELOAD_LOW), 32'h0000_0005);
            apb(1'b1, ta(0, `FLD_MATCH_HIGH), 32'h0000_0001);
            apb(1'b1, ta(0, `FLD_MATCH_LOW), 32'h0000_0000);
            apb(1'b1, ta(0, `FLD_COUNT_LOW), 32'h0000_0001);
            apb(1'b1, ta(0, `FLD_CONTROL), {24'h0, 1'b1, p[0], 4'h0, `MODE_PWM});
            repeat (300) @(posedge clk_sys);
            highs = 0;
            repeat (783) begin
                @(posedge clk_sys);
                highs += (timerOut[0] === 1'b1);
            end
            chk(highs, p ? 32'd768 : 32'd15, "pwm high time");
            apb(1'b1, 16'h3c84, 32'h0000_0001);
            repeat (300) @(posedge clk_sys);
            chk(irq, 1'b1, "pwm irq");
            apb(1'b1, 16'h3c84, 32'h0000_0000);
            apb(1'b1, ta(0, `FLD_CONTROL), 32'h0000_0000);
            apb(1'b1, 16'h3c80, 32'h0000_000f);
            apb(1'b0, 16'h3c80, 32'h0);
            chk(q, 32'h0000_0000, "status cleared");
            $display("test pwm polarity %0d done", p);
        end
        // counter on timer 1: start 0005, reload 0008, rising edges
        apb(1'b1, ta(1, `FLD_RELOAD_LOW), 32'h0000_0008);
        apb(1'b1, ta(1, `FLD_COUNT_LOW), 32'h0000_0005);
        apb(1'b1, 16'h3c84, 32'h0000_0002);
        apb(1'b1, ta(1, `FLD_CONTROL), {24'h0, 1'b1, 5'h00, `MODE_COUNTER});
        pins_u.pulses(1, 2);
        rdc(1, c);
        chk(c, 32'h0000_0007, "two edges");
        pins_u.pulses(1, 2);
        rdc(1, c);
        chk(c, 32'h0000_0001, "restart");
        chk(irq, 1'b1, "counter irq");
        pins_u.pulses(1, 3);
        rdc(1, c);
        chk(c, 32'h0000_0004, "second pass");
        chk(timerOut[1], 1'b1, "counter out toggled");
        // timer 2 counts falling edges only and idles high
        apb(1'b1, ta(2, `FLD_RELOAD_HIGH), 32'h0000_00ff);
        apb(1'b1, ta(2, `FLD_COUNT_LOW), 32'h0000_0001);
        apb(1'b1, ta(2, `FLD_CONTROL), {24'h0, 2'b11, 4'h0, `MODE_COUNTER});
        @(posedge clk_sys);
        chk(timerOut[2], 1'b1, "counter idle high");
        pins_u.set_level(2, 1'b1);
        rdc(2, c);
        chk(c, 32'h0000_0001, "rise ignored");
        pins_u.set_level(2, 1'b0);
        rdc(2, c);
        chk(c, 32'h0000_0002, "fall counted");
        $display("test counter done");
        // timer 3 counts clocks from 0: 1 at the edge after enable, 2 one edge later,
        // and the rising pin set at that edge is seen at the next, so 2 is captured
        apb(1'b1, ta(3, `FLD_CONTROL), {24'h0, 1'b1, 5'h00, `MODE_CAPTURE});
        pins_u.set_level(3, 1'b1);
        apb(1'b0, ta(3, `FLD_MATCH_HIGH), 32'h0);
        chk(q, 32'h0000_0000, "capture high");
        apb(1'b0, ta(3, `FLD_MATCH_LOW), 32'h0);
        chk(q, 32'h0000_0002, "capture low");
        chk(err, 1'b0, "mapped read");
        $display("test capture done");
        end_sim();
    end
endmodule // tb
bind timer_block timer_block_properties chk_u (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerIn(timerIn),
    .timerOut(timerOut), .irq(irq));
